// *** logic/pon_framer_pkg.sv ***
// Shared constants and types of the upstream burst framer and block encoder
package pon_framer_pkg;

	// ----------------------------------------------------------------
	// Line block and codeword geometry
	// ----------------------------------------------------------------
	localparam int BLOCK_W = 257;
	localparam int PARITY_W = 256;
	localparam logic [6:0] FEC_PAYLOAD_SIZE = 7'h38;
	localparam logic [3:0] FEC_PARITY_SIZE = 4'ha;
	localparam logic [9:0] FEC_CW_DELIM = 10'h3ca;
	// End delimiter value is arbitrary until fixed by the system
	localparam logic [256:0] END_DELIM_BLOCK = {1'b0, {32{8'h3c}}};

	// ----------------------------------------------------------------
	// Block timing: 25.78125 Gb/s and 10.3125 Gb/s on a 10 ns clock
	// ----------------------------------------------------------------
	localparam longint LINE_KBPS_25G = 64'h1896402;
	localparam longint LINE_KBPS_10G = 64'h9d5b34;
	localparam longint CLK_PERIOD_PS = 64'h2710;
	localparam longint PS_PER_KS = 64'h3b9aca00;
	localparam longint BLOCK_PS_25G = 64'h101 * PS_PER_KS / LINE_KBPS_25G;
	localparam longint BLOCK_PS_10G = 64'h101 * PS_PER_KS / LINE_KBPS_10G;
	localparam longint CYC_25G_RAW = BLOCK_PS_25G / CLK_PERIOD_PS;
	localparam longint CYC_10G_RAW = BLOCK_PS_10G / CLK_PERIOD_PS;
	localparam logic [3:0] BLOCK_CYC_25G = (CYC_25G_RAW < 1) ? 4'h1 : 4'(CYC_25G_RAW);
	localparam logic [3:0] BLOCK_CYC_10G = (CYC_10G_RAW < 1) ? 4'h1 : 4'(CYC_10G_RAW);

	// ----------------------------------------------------------------
	// 64B/66B block format and control codes
	// ----------------------------------------------------------------
	localparam logic [1:0] SYNC_DATA = 2'h1;
	localparam logic [1:0] SYNC_CTRL = 2'h2;
	localparam logic [7:0] BT_CTRL = 8'h1e;
	localparam logic [7:0] BT_START = 8'h78;
	// Terminate block type per lane of the terminate character, lane 0 lowest
	localparam logic [63:0] BT_TERM = 64'hffe1d2ccb4aa9987;
	localparam logic [7:0] CH_IDLE = 8'h07;
	localparam logic [7:0] CH_IEI = 8'h08;
	localparam logic [7:0] CH_RA = 8'h09;
	localparam logic [7:0] CH_ERR = 8'hfe;
	localparam logic [7:0] CH_START = 8'hfb;
	localparam logic [7:0] CH_TERM = 8'hfd;
	localparam logic [6:0] LC_IDLE = 7'h00;
	localparam logic [6:0] LC_IEI = 7'h08;
	localparam logic [6:0] LC_RA = 7'h09;
	localparam logic [6:0] LC_ERR = 7'h1e;

	// ----------------------------------------------------------------
	// Register map, fields and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ZLEN = 8'h04;
	localparam logic [7:0] ADDR_PAT1 = 8'h08;
	localparam logic [7:0] ADDR_PAT2 = 8'h0c;
	localparam logic [7:0] ADDR_PAT3 = 8'h10;
	localparam logic [7:0] ADDR_FLAGS = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_BURSTS = 8'h1c;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_HEAD_BIT = 1;
	localparam int CTRL_R10_BIT = 2;
	localparam int Z1_LSB = 0;
	localparam int Z2_LSB = 8;
	localparam int Z3_LSB = 16;
	localparam int ST_UNDER_BIT = 8;
	localparam int ST_ERR_LSB = 16;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [23:0] ZLEN_RST = 24'h000404;
	localparam logic [31:0] PAT1_RST = 32'h55555555;
	localparam logic [31:0] PAT2_RST = 32'hbf4018e5;
	localparam logic [31:0] PAT3_RST = 32'h00000000;
	localparam logic [2:0] FLAGS_RST = 3'h1;

	typedef enum logic [6:0] {
		FS_IDLE = 7'h01,
		FS_ZONE_A = 7'h02,
		FS_ZONE_B = 7'h04,
		FS_ZONE_C = 7'h08,
		FS_PAYLOAD = 7'h10,
		FS_PARITY = 7'h20,
		FS_END_DELIM = 7'h40
	} frame_state_type;

endpackage

// *** logic/pon_mii_block_encoder.sv ***
// 64B/66B encoder of 72-bit media independent interface vectors
`timescale 1ns/1ps
module pon_mii_block_encoder (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_mii_valid,
	input wire logic [63:0] i_mii_txd,
	input wire logic [7:0] i_mii_txc,
	output logic o_enc_valid,
	output logic [65:0] o_enc_block,
	output logic o_enc_err
);
	typedef struct packed {
		logic valid;
		logic [65:0] blk;
		logic err;
	} enc_regs_type;

	enc_regs_type q;
	enc_regs_type d;
	logic [55:0] codes;
	logic [55:0] tpl;
	logic [7:0] bad;
	logic found;

	always_comb begin
		d = q;
		codes = '0;
		tpl = '0;
		bad = '0;
		found = 1'b0;
		d.valid = i_mii_valid;
		d.err = 1'b0;
		// 7-bit lane codes; unknown characters become errors
		for (int i = 0; i < 8; i++) begin
			case (i_mii_txd[8*i +: 8])
				pon_framer_pkg::CH_IDLE: codes[7*i +: 7] = pon_framer_pkg::LC_IDLE; // RULE_21
				pon_framer_pkg::CH_IEI: codes[7*i +: 7] = pon_framer_pkg::LC_IEI; // RULE_21
				pon_framer_pkg::CH_RA: codes[7*i +: 7] = pon_framer_pkg::LC_RA; // RULE_21
				pon_framer_pkg::CH_ERR: codes[7*i +: 7] = pon_framer_pkg::LC_ERR; // RULE_21
				default: begin
					codes[7*i +: 7] = pon_framer_pkg::LC_ERR; // RULE_22
					bad[i] = 1'b1; // RULE_18
				end
			endcase
		end
		if (i_mii_txc == 8'h00) begin
			d.blk = {i_mii_txd, pon_framer_pkg::SYNC_DATA}; // RULE_16
		end else if (i_mii_txc == 8'hff && bad == 8'h00) begin
			d.blk = {codes, pon_framer_pkg::BT_CTRL, pon_framer_pkg::SYNC_CTRL};
		end else if (i_mii_txc == 8'h01 && i_mii_txd[7:0] == pon_framer_pkg::CH_START) begin
			// Start travels only as the block type
			d.blk = {i_mii_txd[63:8], pon_framer_pkg::BT_START, pon_framer_pkg::SYNC_CTRL}; // RULE_19
		end else begin
			for (int k = 0; k < 8; k++) begin
				if (!found && i_mii_txc == 8'(8'hff << k)
						&& i_mii_txd[8*k +: 8] == pon_framer_pkg::CH_TERM
						&& (bad >> (k + 1)) == 8'h00) begin
					found = 1'b1;
					tpl = '0;
					for (int j = 0; j < 8; j++) begin
						if (j < k) begin
							tpl[8*j +: 8] = i_mii_txd[8*j +: 8];
						end else if (j > k) begin
							tpl[55 - 7*(7 - j) -: 7] = codes[7*j +: 7];
						end
					end
					d.blk = {tpl, pon_framer_pkg::BT_TERM[8*k +: 8], // RULE_19
						pon_framer_pkg::SYNC_CTRL};
				end
			end
			// Ordered sets and every other mixture leave as an error block
			if (!found) begin
				d.blk = {{8{pon_framer_pkg::LC_ERR}}, pon_framer_pkg::BT_CTRL, // RULE_20
					pon_framer_pkg::SYNC_CTRL}; // RULE_17
				d.err = i_mii_valid; // RULE_22
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_enc_valid = q.valid;
	assign o_enc_block = q.blk;
	assign o_enc_err = q.err;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	a_no_excluded_types: assert property (o_enc_valid && o_enc_block[1:0] == 2'h2 // RULE_17
		|-> !(o_enc_block[9:2] inside {8'h2d, 8'h33, 8'h66, 8'h55, 8'h4b}))
		else $error("excluded block type produced");
	a_error_block: assert property (i_mii_valid && i_mii_txc == 8'h01 // RULE_22
		&& i_mii_txd[7:0] == 8'h9c |=> o_enc_err && o_enc_block[9:2] == 8'h1e)
		else $error("ordered set not turned into error block");
	a_idle_map: assert property (i_mii_valid && i_mii_txc == 8'hff // RULE_21
		&& i_mii_txd == {8{8'h07}} |=> o_enc_block == {56'h0, 8'h1e, 2'h2})
		else $error("idle not mapped to zero code");
endmodule

// *** logic/pon_upstream_burst_framer_encoder.sv ***
// Upstream burst framer with sync zones, FEC codewords and delimiters
// Function
// (RULE_01) Burst opens with zone one, then zone two, then zone three delimiter.
// (RULE_02) Every zone element is a whole 257-bit block.
// (RULE_03) Two-zone preamble: zone one for laser and recovery, zone two delimiter.
// (RULE_04) Zone patterns and zone count come from head-end settings, used as set; zero lengths for zones one and two are used as one.
// (RULE_05) Delimiter is followed by codewords; only the last may be shortened.
// (RULE_06) Codeword sends 56 data blocks then ten parity blocks.
// (RULE_07) Shortened codeword has fewer data blocks but full ten parity blocks.
// (RULE_08) Discovery burst carries exactly one shortened codeword.
// (RULE_09) Every burst ends with an end delimiter after the last codeword.
// (RULE_10) Default preamble has two zones, third zone length zero.
// (RULE_11) Default zone one is leading one and repeated 0x55, balanced.
// (RULE_12) Default zone two is leading one then BF 40 18 E5, unbalanced.
// (RULE_13) Head-end transmits continuously without bursts at full line rate; here it follows the rate bit and can run at 10.3125 Gb/s.
// (RULE_14) Subscriber unit bursts at either of two line rates.
// (RULE_15) Parity from the LDPC encoder is always inserted, never bypassed.
// (RULE_16) Each 72-bit interface vector becomes one 64B/66B block.
// (RULE_17) Block types 0x2D, 0x33, 0x66, 0x55, 0x4B are never produced.
// (RULE_18) Control characters arrive as interface codes and are interpreted here.
// (RULE_19) Start and terminate are carried only by the block type.
// (RULE_20) Ordered-set control codes are neither accepted nor generated.
// (RULE_21) Idle, envelope idle, rate adjust and error codes map to line codes.
// (RULE_22) Unmapped control codes are never sent and count as errors.
// (RULE_23) Four 66-bit blocks are scrambled before transcoding to 257 bits; here both steps are left to an external scrambler and transcoder.
// (RULE_24) Codeword delimiter 0x3CA travels with the parity for alignment.
// (RULE_25) Zones, delimiter, codewords and end delimiter run back to back.
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
module pon_upstream_burst_framer_encoder (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_we,
	input wire logic i_reg_re,
	output logic [31:0] o_reg_rdata,
	input wire logic i_burst_start,
	input wire logic i_burst_discovery,
	input wire logic [7:0] i_burst_codewords,
	input wire logic [6:0] i_burst_last_len,
	output logic o_frame_idle,
	input wire logic i_payload_valid,
	input wire logic [256:0] i_payload_block,
	output logic o_payload_ready,
	input wire logic i_parity_valid,
	input wire logic [255:0] i_parity_word,
	output logic o_parity_ready,
	output logic o_fec_valid,
	output logic [256:0] o_fec_block,
	output logic o_line_valid,
	output logic [256:0] o_line_block,
	output logic o_burst_active,
	input wire logic i_mii_valid,
	input wire logic [63:0] i_mii_txd,
	input wire logic [7:0] i_mii_txc,
	output logic o_enc_valid,
	output logic [65:0] o_enc_block
);
	typedef struct packed {
		pon_framer_pkg::frame_state_type state;
		logic [3:0] div;
		logic [7:0] zone_left;
		logic [7:0] cw_left;
		logic [6:0] pay_left;
		logic [3:0] par_idx;
		logic [6:0] last_len;
		logic disc;
		logic cont;
		logic [256:0] line;
		logic line_valid;
		logic [256:0] fec;
		logic fec_valid;
		logic underrun;
		logic [3:0] ctrl;
		logic [23:0] zlen;
		logic [31:0] pat1;
		logic [31:0] pat2;
		logic [31:0] pat3;
		logic [2:0] flags;
		logic [31:0] rdata;
		logic [15:0] err_cnt;
		logic [15:0] burst_cnt;
	} frame_regs_type;

	localparam frame_regs_type RST = '{
		state: pon_framer_pkg::FS_IDLE,
		ctrl: pon_framer_pkg::CTRL_RST,
		zlen: pon_framer_pkg::ZLEN_RST, // RULE_10
		pat1: pon_framer_pkg::PAT1_RST, // RULE_11
		pat2: pon_framer_pkg::PAT2_RST, // RULE_12
		pat3: pon_framer_pkg::PAT3_RST,
		flags: pon_framer_pkg::FLAGS_RST, // RULE_11
		default: '0
	};

	frame_regs_type q;
	frame_regs_type d;
	logic tick;
	logic enc_err;
	logic [7:0] len1;
	logic [7:0] len2;
	logic [7:0] len3;
	logic [6:0] first_len;
	logic [6:0] req_len;

	// A zone element is a leading one and the pattern word repeated over 256 bits
	function automatic logic [256:0] zone_block(input logic [31:0] w);
		return {1'b1, {8{w}}}; // RULE_02
	endfunction

	// ----------------------------------------------------------------
	// Line encoder
	// ----------------------------------------------------------------
	// Encoded blocks leave for the external scrambler and transcoder
	pon_mii_block_encoder u_encoder ( // RULE_23
		.i_core_clk(i_core_clk),
		.i_resetn(i_resetn),
		.i_mii_valid(i_mii_valid),
		.i_mii_txd(i_mii_txd),
		.i_mii_txc(i_mii_txc),
		.o_enc_valid(o_enc_valid),
		.o_enc_block(o_enc_block),
		.o_enc_err(enc_err)
	);

	// ----------------------------------------------------------------
	// Framer
	// ----------------------------------------------------------------
	assign tick = (q.div == 4'h0);
	// Zero-length zones one and two would break the preamble, so they count as one
	assign len1 = (q.zlen[pon_framer_pkg::Z1_LSB +: 8] == 8'h00) ? 8'h01
		: q.zlen[pon_framer_pkg::Z1_LSB +: 8];
	assign len2 = (q.zlen[pon_framer_pkg::Z2_LSB +: 8] == 8'h00) ? 8'h01
		: q.zlen[pon_framer_pkg::Z2_LSB +: 8];
	assign len3 = q.zlen[pon_framer_pkg::Z3_LSB +: 8];
	assign first_len = (q.cw_left == 8'h01) ? q.last_len
		: pon_framer_pkg::FEC_PAYLOAD_SIZE; // RULE_05
	assign req_len = (i_burst_last_len == 7'h00) ? 7'h01
		: (i_burst_last_len > pon_framer_pkg::FEC_PAYLOAD_SIZE)
		? pon_framer_pkg::FEC_PAYLOAD_SIZE : i_burst_last_len;

	always_comb begin
		d = q;
		d.line_valid = 1'b0;
		d.fec_valid = 1'b0;
		d.rdata = '0;
		if (tick) begin
			d.div = q.ctrl[pon_framer_pkg::CTRL_R10_BIT] // RULE_14
				? pon_framer_pkg::BLOCK_CYC_10G - 4'h1
				: pon_framer_pkg::BLOCK_CYC_25G - 4'h1;
		end else begin
			d.div = q.div - 4'h1;
		end

		// Register writes come first so that a hardware set below wins
		if (i_reg_we) begin
			if (i_reg_addr == pon_framer_pkg::ADDR_CTRL) begin
				d.ctrl = i_reg_wdata[3:0];
			end else if (i_reg_addr == pon_framer_pkg::ADDR_ZLEN) begin
				d.zlen = i_reg_wdata[23:0]; // RULE_04
			end else if (i_reg_addr == pon_framer_pkg::ADDR_PAT1) begin
				d.pat1 = i_reg_wdata; // RULE_04
			end else if (i_reg_addr == pon_framer_pkg::ADDR_PAT2) begin
				d.pat2 = i_reg_wdata; // RULE_04
			end else if (i_reg_addr == pon_framer_pkg::ADDR_PAT3) begin
				d.pat3 = i_reg_wdata; // RULE_04
			end else if (i_reg_addr == pon_framer_pkg::ADDR_FLAGS) begin
				d.flags = i_reg_wdata[2:0];
			end else if (i_reg_addr == pon_framer_pkg::ADDR_STATUS) begin
				if (i_reg_wdata[pon_framer_pkg::ST_UNDER_BIT]) begin
					d.underrun = 1'b0;
				end
			end
		end
		if (i_reg_re) begin
			if (i_reg_addr == pon_framer_pkg::ADDR_CTRL) begin
				d.rdata = {28'h0, q.ctrl};
			end else if (i_reg_addr == pon_framer_pkg::ADDR_ZLEN) begin
				d.rdata = {8'h00, q.zlen};
			end else if (i_reg_addr == pon_framer_pkg::ADDR_PAT1) begin
				d.rdata = q.pat1;
			end else if (i_reg_addr == pon_framer_pkg::ADDR_PAT2) begin
				d.rdata = q.pat2;
			end else if (i_reg_addr == pon_framer_pkg::ADDR_PAT3) begin
				d.rdata = q.pat3;
			end else if (i_reg_addr == pon_framer_pkg::ADDR_FLAGS) begin
				d.rdata = {29'h0, q.flags};
			end else if (i_reg_addr == pon_framer_pkg::ADDR_STATUS) begin
				d.rdata = {q.err_cnt, 7'h00, q.underrun, 1'b0, q.state};
			end else if (i_reg_addr == pon_framer_pkg::ADDR_BURSTS) begin
				d.rdata = {16'h0000, q.burst_cnt};
			end
		end
		if (enc_err && q.err_cnt != 16'hffff) begin
			d.err_cnt = q.err_cnt + 16'h0001; // RULE_22
		end

		if (q.state == pon_framer_pkg::FS_IDLE) begin
			if (q.ctrl[pon_framer_pkg::CTRL_EN_BIT] && q.ctrl[pon_framer_pkg::CTRL_HEAD_BIT]) begin
				// Head-end: codewords while enable and head-end bits stay set, no preamble and no end delimiter
				d.state = pon_framer_pkg::FS_PAYLOAD; // RULE_13
				d.cont = 1'b1;
				d.disc = 1'b0;
				d.cw_left = 8'h00;
				d.pay_left = pon_framer_pkg::FEC_PAYLOAD_SIZE;
			end else if (q.ctrl[pon_framer_pkg::CTRL_EN_BIT] && i_burst_start) begin
				d.state = pon_framer_pkg::FS_ZONE_A; // RULE_01
				d.cont = 1'b0;
				d.disc = i_burst_discovery;
				d.zone_left = len1;
				if (i_burst_discovery) begin
					d.cw_left = 8'h01; // RULE_08
					d.last_len = (req_len == pon_framer_pkg::FEC_PAYLOAD_SIZE)
						? pon_framer_pkg::FEC_PAYLOAD_SIZE - 7'h01 : req_len; // RULE_08
				end else begin
					d.cw_left = (i_burst_codewords == 8'h00) ? 8'h01 : i_burst_codewords;
					d.last_len = req_len; // RULE_05
				end
			end
		end else if (tick) begin
			// Every block slot of a running burst is filled
			d.line_valid = 1'b1; // RULE_25
			case (q.state)
				pon_framer_pkg::FS_ZONE_A: begin
					d.line = zone_block(q.pat1); // RULE_01
					if (q.zone_left == 8'h01) begin
						d.state = pon_framer_pkg::FS_ZONE_B;
						d.zone_left = len2;
					end else begin
						d.zone_left = q.zone_left - 8'h01;
					end
				end
				pon_framer_pkg::FS_ZONE_B: begin
					d.line = zone_block(q.pat2);
					if (q.zone_left == 8'h01) begin
						if (len3 != 8'h00) begin
							d.state = pon_framer_pkg::FS_ZONE_C; // RULE_01
							d.zone_left = len3;
						end else begin
							d.state = pon_framer_pkg::FS_PAYLOAD; // RULE_03
							d.pay_left = first_len;
						end
					end else begin
						d.zone_left = q.zone_left - 8'h01;
					end
				end
				pon_framer_pkg::FS_ZONE_C: begin
					d.line = zone_block(q.pat3);
					if (q.zone_left == 8'h01) begin
						d.state = pon_framer_pkg::FS_PAYLOAD; // RULE_05
						d.pay_left = first_len;
					end else begin
						d.zone_left = q.zone_left - 8'h01;
					end
				end
				pon_framer_pkg::FS_PAYLOAD: begin
					// A missing block is replaced by a zone one filler and flagged
					if (i_payload_valid) begin
						d.line = i_payload_block;
					end else begin
						d.line = zone_block(q.pat1);
						d.underrun = 1'b1;
					end
					d.fec = d.line; // RULE_15
					d.fec_valid = 1'b1;
					if (q.pay_left == 7'h01) begin
						d.state = pon_framer_pkg::FS_PARITY; // RULE_06
						d.par_idx = 4'h0;
					end else begin
						d.pay_left = q.pay_left - 7'h01;
					end
				end
				pon_framer_pkg::FS_PARITY: begin
					// One delimiter bit, high bit first, rides above each parity word
					d.line = {pon_framer_pkg::FEC_CW_DELIM[4'h9 - q.par_idx], // RULE_24
						i_parity_valid ? i_parity_word : 256'h0}; // RULE_15
					if (!i_parity_valid) begin
						d.underrun = 1'b1;
					end
					if (q.par_idx == pon_framer_pkg::FEC_PARITY_SIZE - 4'h1) begin // RULE_07
						if (q.cont) begin
							if (q.ctrl[pon_framer_pkg::CTRL_EN_BIT]
									&& q.ctrl[pon_framer_pkg::CTRL_HEAD_BIT]) begin
								d.state = pon_framer_pkg::FS_PAYLOAD; // RULE_13
								d.pay_left = pon_framer_pkg::FEC_PAYLOAD_SIZE;
							end else begin
								d.state = pon_framer_pkg::FS_IDLE;
								d.cont = 1'b0;
							end
						end else if (q.cw_left == 8'h01) begin
							d.state = pon_framer_pkg::FS_END_DELIM; // RULE_09
						end else begin
							d.cw_left = q.cw_left - 8'h01;
							d.state = pon_framer_pkg::FS_PAYLOAD;
							d.pay_left = (q.cw_left == 8'h02) ? q.last_len
								: pon_framer_pkg::FEC_PAYLOAD_SIZE; // RULE_05
						end
					end else begin
						d.par_idx = q.par_idx + 4'h1;
					end
				end
				pon_framer_pkg::FS_END_DELIM: begin
					d.line = pon_framer_pkg::END_DELIM_BLOCK; // RULE_09
					d.state = pon_framer_pkg::FS_IDLE;
					d.burst_cnt = q.burst_cnt + 16'h0001;
				end
				default: begin
					d.line_valid = 1'b0;
					d.state = pon_framer_pkg::FS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			q <= RST;
		end else begin
			q <= d;
		end
	end

	assign o_reg_rdata = q.rdata;
	assign o_frame_idle = (q.state == pon_framer_pkg::FS_IDLE);
	assign o_burst_active = (q.state != pon_framer_pkg::FS_IDLE);
	assign o_payload_ready = tick && q.state == pon_framer_pkg::FS_PAYLOAD;
	assign o_parity_ready = tick && q.state == pon_framer_pkg::FS_PARITY;
	assign o_fec_valid = q.fec_valid;
	assign o_fec_block = q.fec;
	assign o_line_valid = q.line_valid;
	assign o_line_block = q.line;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	a_zone_one_next: assert property (q.state == pon_framer_pkg::FS_ZONE_A && tick // RULE_01
		&& q.zone_left == 8'h01 |=> q.state == pon_framer_pkg::FS_ZONE_B)
		else $error("zone one not followed by zone two");
	a_zone_lead_one: assert property (o_line_valid // RULE_02
		&& $past(q.state) inside {pon_framer_pkg::FS_ZONE_A, pon_framer_pkg::FS_ZONE_B}
		|-> o_line_block[256] && o_line_block[255:224] == o_line_block[31:0])
		else $error("zone block malformed");
	a_two_zone_end: assert property (q.state == pon_framer_pkg::FS_ZONE_B && tick // RULE_03
		&& q.zone_left == 8'h01 && len3 == 8'h00 |=> q.state == pon_framer_pkg::FS_PAYLOAD)
		else $error("two-zone preamble not followed by payload");
	a_payload_parity: assert property (q.state == pon_framer_pkg::FS_PAYLOAD && tick // RULE_06
		&& q.pay_left == 7'h01 |=> q.state == pon_framer_pkg::FS_PARITY && q.par_idx == 4'h0)
		else $error("payload end not followed by parity");
	a_parity_length: assert property (q.state == pon_framer_pkg::FS_PARITY && tick // RULE_07
		&& q.par_idx == 4'h9 |=> q.state != pon_framer_pkg::FS_PARITY)
		else $error("parity portion not ten blocks");
	a_discovery_short: assert property (q.disc && q.state != pon_framer_pkg::FS_IDLE // RULE_08
		|-> q.cw_left == 8'h01 && q.last_len < 7'h38)
		else $error("discovery burst not one shortened codeword");
	a_end_delim: assert property (q.state == pon_framer_pkg::FS_END_DELIM && tick // RULE_09
		|=> o_line_valid && o_line_block == pon_framer_pkg::END_DELIM_BLOCK && o_frame_idle)
		else $error("end delimiter missing");
	a_no_gap: assert property (q.state != pon_framer_pkg::FS_IDLE && tick // RULE_25
		|=> o_line_valid)
		else $error("gap inside burst");
	a_head_no_zone: assert property (q.cont // RULE_13
		|-> q.state inside {pon_framer_pkg::FS_PAYLOAD, pon_framer_pkg::FS_PARITY})
		else $error("head-end left continuous codewords");
	a_delim_top: assert property (o_line_valid && $past(q.state) == pon_framer_pkg::FS_PARITY // RULE_24
		&& $past(q.par_idx) == 4'h0 |-> o_line_block[256] == 1'b1)
		else $error("codeword delimiter bit wrong");

	c_three_zone: cover property (q.state == pon_framer_pkg::FS_ZONE_C && tick);
	c_discovery: cover property (q.disc && q.state == pon_framer_pkg::FS_END_DELIM);
	c_head_end: cover property (q.cont && q.state == pon_framer_pkg::FS_PARITY);
	c_underrun: cover property (q.underrun);
endmodule

// *** testbench/fec_source_model.sv ***
// Payload and parity source standing beside the framer
`timescale 1ns/1ps
module fec_source_model (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_payload_ready,
	input wire logic i_parity_ready,
	output logic o_payload_valid,
	output logic [256:0] o_payload_block,
	output logic o_parity_valid,
	output logic [255:0] o_parity_word
);
	// Data moves on only when taken, so a missed ready shows as repeated data
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_payload_valid <= 1'b0;
			o_parity_valid <= 1'b0;
			o_payload_block <= {1'b1, {32{8'ha5}}};
			o_parity_word <= {32{8'h3c}};
		end else begin
			o_payload_valid <= 1'b1;
			o_parity_valid <= 1'b1;
			if (i_payload_ready) o_payload_block <= ~o_payload_block;
			if (i_parity_ready) o_parity_word <= ~o_parity_word;
		end
	end
endmodule

// *** testbench/pon_upstream_burst_framer_encoder_bench.sv ***
// Self-checking bench of the burst framer and block encoder
`timescale 1ns/1ps
module pon_upstream_burst_framer_encoder_bench;
	logic clk = 0, rstn = 0, we = 0, re = 0, st = 0, pv, yv, mv = 0, lv, fi, ds = 0, fv, ba, ev;
	logic [7:0] ad = 0, txc = 0;
	logic [31:0] wd = 0, rd;
	logic [63:0] txd = 0;
	logic [65:0] eb;
	logic [256:0] pb, lb, fb;
	logic [255:0] pw;
	logic pr, yr;
	int error_cnt = 0, comparisons = 0;
	always #5 clk = ~clk;
	pon_upstream_burst_framer_encoder uut (.i_core_clk(clk), .i_resetn(rstn), .i_reg_addr(ad),
		.i_reg_wdata(wd), .i_reg_we(we), .i_reg_re(re), .o_reg_rdata(rd), .i_burst_start(st),
		.i_burst_discovery(ds), .i_burst_codewords(8'h01), .i_burst_last_len(7'h01),
		.o_frame_idle(fi), .i_payload_valid(pv), .i_payload_block(pb), .o_payload_ready(pr),
		.i_parity_valid(yv), .i_parity_word(pw), .o_parity_ready(yr), .o_fec_valid(fv),
		.o_fec_block(fb), .o_line_valid(lv), .o_line_block(lb), .o_burst_active(ba),
		.i_mii_valid(mv), .i_mii_txd(txd), .i_mii_txc(txc), .o_enc_valid(ev), .o_enc_block(eb));
	fec_source_model partner (.i_core_clk(clk), .i_resetn(rstn), .i_payload_ready(pr),
		.i_parity_ready(yr), .o_payload_valid(pv), .o_payload_block(pb),
		.o_parity_valid(yv), .o_parity_word(pw));
	task automatic chk(input logic [256:0] seen, input logic [256:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk) begin ad <= a; re <= 1; end
		@(posedge clk) re <= 0;
		#1 chk(rd, exp);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic defaults();
		rdchk(pon_framer_pkg::ADDR_ZLEN, 32'h00000404);
		rdchk(pon_framer_pkg::ADDR_PAT1, 32'h55555555);
		rdchk(pon_framer_pkg::ADDR_PAT2, 32'hbf4018e5);
		rdchk(pon_framer_pkg::ADDR_FLAGS, 32'h00000001);
		rdchk(8'h3c, 32'h00000000);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk) begin ad <= a; wd <= v; we <= 1; end
		@(posedge clk) we <= 0;
	endtask
	task automatic encode();
		logic [63:0] d[6] = '{{8{8'h07}}, {8{8'hfe}}, {8{8'h5a}}, 64'h55fb, 64'h1122, 64'h9c};
		logic [7:0] c[6] = '{8'hff, 8'hff, 8'hff, 8'h01, 8'h00, 8'h01};
		logic [16:0] e[6] = '{{7'h00, 8'h1e, 2'h2}, {7'h1e, 8'h1e, 2'h2}, {7'h1e, 8'h1e, 2'h2},
			{7'h55, 8'h78, 2'h2}, {7'h11, 8'h22, 2'h1}, {7'h1e, 8'h1e, 2'h2}};
		for (int i = 0; i < 6; i++) begin
			@(posedge clk) begin mv <= 1; txd <= d[i]; txc <= c[i]; end
			@(posedge clk) mv <= 0;
			#1 chk(eb[16:0], e[i]);
			chk(ev, 1'b1);
		end
		// Two error vectors were sent: the bad lanes and the ordered set
		rdchk(pon_framer_pkg::ADDR_STATUS, 32'h00020001);
	endtask
	task automatic burst(input logic disc);
		int n = 0;
		logic [9:0] dl = 0;
		logic [256:0] pl = {1'b1, {32{8'ha5}}} ^ {257{disc}};
		wr(pon_framer_pkg::ADDR_CTRL, 32'h1);
		st <= 1;
		ds <= disc;
		@(posedge clk) st <= 0;
		for (int k = 0; k < 40; k++) begin
			@(posedge clk) #1;
			if (lv === 1'b1) begin
				n++;
				if (n <= 4) chk(lb, {1'b1, {8{32'h55555555}}});
				if (n > 4 && n <= 8) chk(lb, {1'b1, {8{32'hbf4018e5}}});
				if (n == 1) chk(ba, 1'b1);
				if (n == 9) chk(lb, pl);
				if (n == 9) chk(fb, pl);
				if (n == 9) chk(fv, 1'b1);
				if (n == 10) chk(lb[255:0], {32{8'h3c}});
				if (n > 9 && n < 20) dl[19 - n] = lb[256];
				if (n == 20) chk(lb, pon_framer_pkg::END_DELIM_BLOCK);
			end
		end
		chk(n, 20);
		chk(dl, pon_framer_pkg::FEC_CW_DELIM);
		chk(fi, 1'b1);
		chk(ba, 1'b0);
		rdchk(pon_framer_pkg::ADDR_BURSTS, {31'h0, disc} + 32'h1);
	endtask
	task automatic head();
		int n = 0;
		// Continuous codewords at the slower rate: one block every second cycle
		wr(pon_framer_pkg::ADDR_CTRL, 32'h7);
		for (int k = 0; k < 8 && lv !== 1'b1; k++) @(posedge clk) #1;
		for (int k = 0; k < 40; k++) begin
			if (lv === 1'b1) n++;
			@(posedge clk) #1;
		end
		chk(n, 20);
		chk(fi, 1'b0);
		wr(pon_framer_pkg::ADDR_CTRL, 32'h0);
		for (int k = 0; k < 200 && fi !== 1'b1; k++) @(posedge clk) #1;
		chk(fi, 1'b1);
	endtask
	task automatic results();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt++;
		results();
	end
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1;
		defaults();
		encode();
		burst(1'b0);
		burst(1'b1);
		head();
		results();
	end
endmodule
